// ===== pkg/csf_pkg.sv
// Package with register map, field positions and carrier types of the clock status flag unit
package csf_pkg;
	localparam logic [7:0] ADDR_FLAGS = 8'h00;
	localparam logic [7:0] ADDR_ENABLES = 8'h08;
	localparam logic [7:0] ADDR_DIVCTL = 8'h0c;
	localparam int BIT_TICK = 7;
	localparam int BIT_LOCKCHG = 4;
	localparam int BIT_LOCK = 3;
	localparam int BIT_OSCCHG = 1;
	localparam int BIT_OSCQ = 0;
	localparam logic [7:0] FLAG_W1C_MASK = 8'h92;
	localparam logic [7:0] ENABLE_MASK = 8'h92;
	localparam logic [7:0] ENABLES_RESET = 8'h00;
	localparam logic [3:0] PLL_POST_DIVIDER_RESET = 4'h0;
	localparam logic [3:0] UNLOCKED_DIV_M1 = 4'h3;
	localparam int TICK_PERIOD_NS = 1000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} csf_bus_s;

	typedef struct packed {
		logic tick;
		logic lockChg;
		logic oscChg;
	} csf_flags_s;

	typedef enum logic [1:0] {
		CSF_OSC_OFF = 2'b00,
		CSF_OSC_QUAL = 2'b01,
		CSF_OSC_STOP = 2'b11
	} csf_osc_e;
endpackage

// ===== src/csf_clock_status_flag_unit.sv
// Clock status flags, interrupt request and PLL output divider of the clock management unit
//
// Chosen here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

// How it works
// - Tick period expiry sets flag bit 7
// - Flags clear only on written one
// - Tick flag with enable raises interrupt
// - Any lock status change sets bit 4
// - Lock-change flag with enable raises interrupt
// - Bit 3 shows live lock, read-only
// - Unlocked PLL output is VCO over four
// - Locked output is VCO over pll_post_divider+1
// - Qualified status change sets bit 1
// - Osc-change flag with enable raises interrupt
// - Bit 0 reads one only when qualified
// - Full stop entry clears qualified status
// - Enables at bits 7,4,1 offset 0x0008
module csf_clock_status_flag_unit (
	input wire logic clk_sys,
	input wire logic rst,
	input wire csf_pkg::csf_bus_s bus,
	output logic [7:0] rdata,
	input wire logic pllLockIn,
	input wire logic oscGoodIn,
	input wire logic fullStopReq,
	input wire logic vcoClkEn,
	output logic pllClkEn,
	output logic pllLocked,
	output logic oscQualified,
	output logic irqReq
);
	// Channel 0 carries the PLL lock level, channel 1 the oscillator level
	logic [1:0] statusIn;
	logic [1:0] status_r;
	logic [1:0] status_nxt;
	logic lock_r;
	logic lock_nxt;
	logic oscGood_r;
	logic stopSeen_r;
	logic stopSeen_nxt;
	csf_pkg::csf_osc_e oscState_r;
	csf_pkg::csf_osc_e oscState_nxt;
	logic [2:0] flagBits_r;
	logic [2:0] flagBits_nxt;
	logic [2:0] flagEvt;
	logic [2:0] flagClr;
	csf_pkg::csf_flags_s flags_r;
	csf_pkg::csf_flags_s flags_nxt;
	logic [7:0] enables_r;
	logic [7:0] enables_nxt;
	logic [3:0] pll_post_divider_r;
	logic [3:0] pll_post_divider_nxt;
	logic [15:0] tickCnt_r;
	logic [15:0] tickCnt_nxt;
	logic [3:0] divCnt_r;
	logic [3:0] divCnt_nxt;
	logic [3:0] divLimit;
	logic pllClkEn_nxt;
	logic [7:0] rdata_nxt;
	logic irq_nxt;
	logic irqTick;
	logic irqLock;
	logic irqOsc;
	logic pllLocked_nxt;
	logic oscQualified_nxt;
	logic [7:0] flagView;
	logic wrFlags;
	logic wrEn;
	logic wrDiv;
	logic tickEvt;
	logic lockEvt;
	logic oscEvt;
	logic oscQ;
	logic oscQ_nxt;

	assign statusIn = {oscGoodIn, pllLockIn};
	assign lock_r = status_r[0];
	assign lock_nxt = status_nxt[0];
	assign oscGood_r = status_r[1];

	// Analog levels are asynchronous, so each passes three flops before use
	for (genvar i = 0; i < 2; i++) begin : g_sync
		logic [2:0] stage_r;
		logic [2:0] stage_nxt;
		logic level_r;
		logic level_nxt;
		always_comb begin
			stage_nxt = {stage_r[1:0], statusIn[i]};
			// A change counts only once the second and third stage agree
			level_nxt = (stage_r[2] == stage_r[1]) ? stage_r[2] : level_r;
		end
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				stage_r <= 3'h0;
				level_r <= 1'b0;
			end else begin
				stage_r <= stage_nxt;
				level_r <= level_nxt;
			end
		end
		assign status_r[i] = level_r;
		assign status_nxt[i] = level_nxt;
	end

	always_comb begin
		stopSeen_nxt = fullStopReq;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			stopSeen_r <= 1'b0;
		end else begin
			stopSeen_r <= stopSeen_nxt;
		end
	end

	always_comb begin
		oscState_nxt = oscState_r;
		case (oscState_r)
			csf_pkg::CSF_OSC_OFF: begin
				if (fullStopReq)
					oscState_nxt = csf_pkg::CSF_OSC_STOP;
				else if (oscGood_r && lock_r)
					oscState_nxt = csf_pkg::CSF_OSC_QUAL;
			end
			csf_pkg::CSF_OSC_QUAL: begin
				if (fullStopReq && !stopSeen_r)
					oscState_nxt = csf_pkg::CSF_OSC_STOP;
				else if (!oscGood_r)
					oscState_nxt = csf_pkg::CSF_OSC_OFF;
			end
			csf_pkg::CSF_OSC_STOP: begin
				if (!fullStopReq)
					oscState_nxt = csf_pkg::CSF_OSC_OFF;
			end
			default: oscState_nxt = csf_pkg::CSF_OSC_OFF;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			oscState_r <= csf_pkg::CSF_OSC_OFF;
		end else begin
			oscState_r <= oscState_nxt;
		end
	end

	assign oscQ = (oscState_r == csf_pkg::CSF_OSC_QUAL);
	assign oscQ_nxt = (oscState_nxt == csf_pkg::CSF_OSC_QUAL);
	assign lockEvt = (lock_nxt != lock_r);
	assign oscEvt = (oscQ_nxt != oscQ);
	assign tickEvt = (tickCnt_r == csf_pkg::TICK_LAST);
	assign flagEvt = {tickEvt, lockEvt, oscEvt};
	assign flags_r = csf_pkg::csf_flags_s'(flagBits_r);
	assign flags_nxt = csf_pkg::csf_flags_s'(flagBits_nxt);
	assign wrFlags = bus.wr && (bus.addr == csf_pkg::ADDR_FLAGS);
	assign wrEn = bus.wr && (bus.addr == csf_pkg::ADDR_ENABLES);
	assign wrDiv = bus.wr && (bus.addr == csf_pkg::ADDR_DIVCTL);

	// Entry 2 is the tick flag, 1 the lock change flag, 0 the oscillator change flag
	for (genvar i = 0; i < 3; i++) begin : g_flag
		localparam int POS = (i == 2) ? csf_pkg::BIT_TICK : ((i == 1) ? csf_pkg::BIT_LOCKCHG : csf_pkg::BIT_OSCCHG);
		logic bit_r;
		logic bit_nxt;
		assign flagClr[i] = wrFlags && bus.wdata[POS];
		// A same-cycle event wins over the clear, so no event is ever lost
		always_comb begin
			bit_nxt = bit_r;
			if (flagClr[i]) begin
				bit_nxt = 1'b0;
			end
			if (flagEvt[i]) begin
				bit_nxt = 1'b1;
			end
		end
		always_ff @(posedge clk_sys) begin
			if (rst) begin
				bit_r <= 1'b0;
			end else begin
				bit_r <= bit_nxt;
			end
		end
		assign flagBits_r[i] = bit_r;
		assign flagBits_nxt[i] = bit_nxt;
	end

	always_comb begin
		if (tickEvt) begin
			tickCnt_nxt = 16'h0000;
		end else begin
			tickCnt_nxt = tickCnt_r + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			tickCnt_r <= 16'h0000;
		end else begin
			tickCnt_r <= tickCnt_nxt;
		end
	end

	always_comb begin
		enables_nxt = enables_r;
		pll_post_divider_nxt = pll_post_divider_r;
		if (wrEn) begin
			enables_nxt = bus.wdata & csf_pkg::ENABLE_MASK;
		end
		if (wrDiv) begin
			pll_post_divider_nxt = bus.wdata[3:0];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			enables_r <= csf_pkg::ENABLES_RESET;
			pll_post_divider_r <= csf_pkg::PLL_POST_DIVIDER_RESET;
		end else begin
			enables_r <= enables_nxt;
			pll_post_divider_r <= pll_post_divider_nxt;
		end
	end

	always_comb begin
		flagView = 8'h00;
		flagView[csf_pkg::BIT_TICK] = flags_r.tick;
		flagView[csf_pkg::BIT_LOCKCHG] = flags_r.lockChg;
		flagView[csf_pkg::BIT_LOCK] = lock_r;
		flagView[csf_pkg::BIT_OSCCHG] = flags_r.oscChg;
		flagView[csf_pkg::BIT_OSCQ] = oscQ;
		rdata_nxt = 8'h00;
		if (bus.rd) begin
			case (bus.addr)
				csf_pkg::ADDR_FLAGS: rdata_nxt = flagView;
				csf_pkg::ADDR_ENABLES: rdata_nxt = enables_r;
				csf_pkg::ADDR_DIVCTL: rdata_nxt = {4'h0, pll_post_divider_r};
				default: rdata_nxt = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rdata <= 8'h00;
		end else begin
			rdata <= rdata_nxt;
		end
	end

	// Built from next values so the request moves on the same edge as its flag
	always_comb begin
		irqTick = flags_nxt.tick && enables_nxt[csf_pkg::BIT_TICK];
		irqLock = flags_nxt.lockChg && enables_nxt[csf_pkg::BIT_LOCKCHG];
		irqOsc = flags_nxt.oscChg && enables_nxt[csf_pkg::BIT_OSCCHG];
		irq_nxt = irqTick || irqLock || irqOsc;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			irqReq <= 1'b0;
		end else begin
			irqReq <= irq_nxt;
		end
	end

	// Output clock as an enable: one pulse per divLimit+1 VCO enables
	always_comb begin
		divLimit = lock_r ? pll_post_divider_r : csf_pkg::UNLOCKED_DIV_M1;
		divCnt_nxt = divCnt_r;
		pllClkEn_nxt = 1'b0;
		if (vcoClkEn) begin
			if (divCnt_r >= divLimit) begin
				divCnt_nxt = 4'h0;
				pllClkEn_nxt = 1'b1;
			end else begin
				divCnt_nxt = divCnt_r + 4'h1;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			divCnt_r <= 4'h0;
			pllClkEn <= 1'b0;
		end else begin
			divCnt_r <= divCnt_nxt;
			pllClkEn <= pllClkEn_nxt;
		end
	end

	// Status outputs move on the same edge as their read-back view
	always_comb begin
		pllLocked_nxt = lock_nxt;
		oscQualified_nxt = oscQ_nxt;
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pllLocked <= 1'b0;
			oscQualified <= 1'b0;
		end else begin
			pllLocked <= pllLocked_nxt;
			oscQualified <= oscQualified_nxt;
		end
	end
endmodule

// ===== test/csf_checker.sv
// Port assertions for the clock status flag unit
`timescale 1ns/1ps
module csf_checker (
	input wire logic clk_sys,
	input wire logic rst,
	input wire csf_pkg::csf_bus_s bus,
	input wire logic [7:0] rdata,
	input wire logic fullStopReq,
	input wire logic pllLocked,
	input wire logic oscQualified,
	input wire logic irqReq
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// High in the cycle where rdata carries the flag register
	logic rf;
	always_ff @(posedge clk_sys) begin
		rf <= bus.rd && bus.addr == csf_pkg::ADDR_FLAGS;
	end
	property p_rsv; rf |-> rdata[6:5] == 2'b00 && !rdata[2]; endproperty
	a_rsv: assert property (p_rsv) else $error("unused flag bit set");
	property p_lk; rf |-> rdata[3] == $past(pllLocked); endproperty
	a_lk: assert property (p_lk) else $error("lock bit differs");
	property p_oq; rf |-> rdata[0] == $past(oscQualified); endproperty
	a_oq: assert property (p_oq) else $error("qualified bit differs");
	property p_lc; rf && $past(pllLocked, 2) != $past(pllLocked) |-> rdata[4]; endproperty
	a_lc: assert property (p_lc) else $error("lock change not flagged");
	property p_oc; rf && $past(oscQualified, 2) != $past(oscQualified) |-> rdata[1]; endproperty
	a_oc: assert property (p_oc) else $error("osc change not flagged");
	property p_fs; fullStopReq |=> !oscQualified; endproperty
	a_fs: assert property (p_fs) else $error("qualified during stop");
	property p_en; bus.wr && bus.addr == csf_pkg::ADDR_ENABLES && bus.wdata == 8'h00 |=> !irqReq; endproperty
	a_en: assert property (p_en) else $error("request with enables off");
	property p_rdz; !$past(bus.rd) |-> rdata == 8'h00; endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside read slot");
	c_lc: cover property (rf && rdata[4]);
	c_oq: cover property ($fell(oscQualified));
	c_irq: cover property ($rose(irqReq));
endmodule
bind csf_clock_status_flag_unit csf_checker u_chk (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata),
	.fullStopReq(fullStopReq), .pllLocked(pllLocked), .oscQualified(oscQualified), .irqReq(irqReq));

// ===== test/clock_status_flag_unit_tb.sv
// Self-checking bench for the clock status flag unit
`timescale 1ns/1ps
module clock_status_flag_unit_tb;
	logic clk_sys = 0, rst = 1, lockIn = 0, oscIn = 0, stopReq = 0, vco = 0;
	logic clkEn, locked, qual, irq;
	logic [7:0] rdata, d;
	csf_pkg::csf_bus_s bus = '0;
	int err_total = 0, n_tests = 0, seed = 32'he9c0f80d, cnt = 0, per = 0;
	always #2.5 clk_sys = ~clk_sys;
	csf_clock_status_flag_unit dut (.clk_sys(clk_sys), .rst(rst), .bus(bus), .rdata(rdata), .pllLockIn(lockIn),
		.oscGoodIn(oscIn), .fullStopReq(stopReq), .vcoClkEn(vco), .pllClkEn(clkEn), .pllLocked(locked),
		.oscQualified(qual), .irqReq(irq));
	// Random VCO pulses; count them between output pulses
	always @(posedge clk_sys) begin
		vco <= 1'($random(seed));
		cnt <= clkEn ? int'(vco) : cnt + int'(vco);
		if (clkEn) begin
			per <= cnt;
		end
	end
	function automatic logic [7:0] expDiv(input logic lk, input logic [7:0] pd);
		return lk ? pd + 8'h01 : 8'h04;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// A gap cycle after each strobe keeps one assignment per time step
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		bus <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_sys);
		bus <= '0;
		@(posedge clk_sys);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		bus <= '{a, 8'h00, 1'b0, 1'b1};
		@(posedge clk_sys);
		bus <= '0;
		#1 chk(rdata & m, e);
		@(posedge clk_sys);
	endtask
	task automatic close_out;
		if (err_total == 0 && n_tests > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		rdc(csf_pkg::ADDR_FLAGS, 8'hff, 8'h00);
		rdc(csf_pkg::ADDR_ENABLES, 8'hff, csf_pkg::ENABLES_RESET);
		d = 8'($random(seed));
		wr(csf_pkg::ADDR_ENABLES, d);
		rdc(csf_pkg::ADDR_ENABLES, 8'hff, d & csf_pkg::ENABLE_MASK);
		rdc(8'h04, 8'hff, 8'h00);
		wr(csf_pkg::ADDR_ENABLES, 8'h80);
		repeat (200) @(posedge clk_sys);
		rdc(csf_pkg::ADDR_FLAGS, 8'hff, 8'h80);
		chk({7'h0, irq}, 8'h01);
		wr(csf_pkg::ADDR_FLAGS, 8'h6d);
		rdc(csf_pkg::ADDR_FLAGS, 8'hff, 8'h80);
		wr(csf_pkg::ADDR_FLAGS, 8'h80);
		rdc(csf_pkg::ADDR_FLAGS, 8'hff, 8'h00);
		wr(csf_pkg::ADDR_ENABLES, 8'h10);
		lockIn <= 1;
		repeat (6) @(posedge clk_sys);
		chk({7'h0, locked}, 8'h01);
		rdc(csf_pkg::ADDR_FLAGS, 8'h7f, 8'h18);
		chk({7'h0, irq}, 8'h01);
		wr(csf_pkg::ADDR_FLAGS, 8'h10);
		rdc(csf_pkg::ADDR_FLAGS, 8'h7f, 8'h08);
		wr(csf_pkg::ADDR_DIVCTL, 8'h02);
		repeat (40) @(posedge clk_sys);
		chk(8'(per), expDiv(1'b1, 8'h02));
		wr(csf_pkg::ADDR_ENABLES, 8'h02);
		oscIn <= 1;
		for (int i = 0; i < 10 && qual !== 1'b1; i++) @(posedge clk_sys);
		chk({7'h0, qual}, 8'h01);
		rdc(csf_pkg::ADDR_FLAGS, 8'h7f, 8'h0b);
		chk({7'h0, irq}, 8'h01);
		wr(csf_pkg::ADDR_FLAGS, 8'h02);
		stopReq <= 1;
		repeat (2) @(posedge clk_sys);
		chk({7'h0, qual}, 8'h00);
		lockIn <= 0;
		repeat (6) @(posedge clk_sys);
		stopReq <= 0;
		rdc(csf_pkg::ADDR_FLAGS, 8'h7f, 8'h12);
		repeat (40) @(posedge clk_sys);
		chk(8'(per), expDiv(1'b0, 8'h02));
		wr(csf_pkg::ADDR_ENABLES, 8'h00);
		chk({7'h0, irq}, 8'h00);
		close_out();
	end
endmodule
